// File: rod_pkg.sv
package rod_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int MSG_N = 16; // Diagnostic messages
  localparam int MSG_W = 4; // Message index width
  localparam int ST_N = 5; // Assembly status signals
  localparam int T1_W = 15; // Pulse length in ms
  localparam int ACC_W = 24; // Off-interval accumulator
  // ----------------------------------------
  // Settings and defaults
  // ----------------------------------------
  localparam logic [7:0] RATE_MIN = 8'h01; // 1 per minute
  localparam logic [7:0] RATE_MAX = 8'hb4; // 180 per minute
  localparam logic [7:0] RATE_DEF = 8'h3c; // 60 per minute
  localparam logic [7:0] DEMAND_FULL = 8'hff; // Full demand
  localparam logic [T1_W-1:0] HALF_MIN_MS = 15'h7530; // 30000 ms
  localparam logic [ST_N-1:0] ST_RESET = 5'h00; // All disabled
  localparam int ST_OK = 0; // Status bit of ok signal
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 5000; // 200 MHz
  localparam int MS_PS = 1000000000; // One millisecond
  localparam int MS_CYC = MS_PS / CLK_PERIOD_PS; // Cycles per ms
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {FN_CTRL, FN_DIAG, FN_STAT} rod_func_type;
  typedef enum logic [2:0] {DM_ASSIGNED, DM_MAINT, DM_SPEC, DM_CHECK, DM_FAIL} rod_dmode_type;
  typedef enum logic [1:0] {CL_MAINT, CL_SPEC, CL_CHECK, CL_FAIL} rod_class_type;
  typedef enum logic [1:0] {HB_FREEZE, HB_FIXED, HB_IGNORE} rod_hold_type;
  typedef struct packed {
    logic map_we; // Map write strobe
    logic class_we; // Class write strobe
    logic [MSG_W-1:0] idx; // Message index
    logic map_val; // Mapped to this relay
    rod_class_type class_val; // New class
  } rod_msg_wr_type;
endpackage : rod_pkg

// File: rod_relay.sv
`timescale 1ns/1ps
// Functional notes
// - Max pulse rate 1 to 180, default 60
// - Pulse length derived from max rate
// - Diagnostic relay energized unless error present
// - Alarm relay always fail-safe
// - Assigned mode uses only mapped messages
// - Class mode uses all class messages, reassignable
// - Mode default assigned, alarm relay failure
// - Mapping refused unless function is diagnostics
// - Mapped list readable, not writable there
// - Status signals enabled individually, none after reset
// - Hold freeze, fixed or ignore; default ignore
// - Constant on time, equal off at max
module rod_relay #(
  parameter int MS_CYCLES = rod_pkg::MS_CYC
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic ALARM_RELAY,
  input wire rod_pkg::rod_func_type FUNC_SEL,
  input wire logic DMODE_WE,
  input wire rod_pkg::rod_dmode_type DMODE_VAL,
  input wire logic RATE_WE,
  input wire logic [7:0] RATE_VAL,
  input wire logic [7:0] DEMAND,
  input wire rod_pkg::rod_msg_wr_type MSG_WR,
  input wire logic [rod_pkg::MSG_N-1:0] MSG_ACTIVE,
  input wire logic [rod_pkg::MSG_W-1:0] MAP_RD_IDX,
  input wire logic STAT_EN_WE,
  input wire logic [rod_pkg::ST_N-1:0] STAT_EN_VAL,
  input wire logic [rod_pkg::ST_N-1:0] ASM_STATUS,
  input wire logic HOLD,
  input wire logic HOLD_WE,
  input wire rod_pkg::rod_hold_type HOLD_VAL,
  input wire logic HOLD_FIXED,
  output logic RELAY_COIL,
  output logic MAP_REJECT,
  output logic RATE_REJECT,
  output logic MAP_RD_DATA,
  output logic [7:0] RATE_NOW
);
  import rod_pkg::*;

  // Pulse length in ms for a given max rate
  function automatic logic [T1_W-1:0] pulse_ms(input logic [7:0] rate);
    pulse_ms = HALF_MIN_MS / T1_W'(rate);
  endfunction : pulse_ms

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic {PS_OFF, PS_ON} rod_pstate_type;
  logic alarm_ff; // Relay is the alarm relay
  rod_dmode_type dmode_ff; // Diagnostic mode
  logic [7:0] rate_ff; // Max pulse rate
  logic [T1_W-1:0] t1_ms_ff; // Pulse length
  logic [MSG_N-1:0] map_ff; // Messages mapped here
  rod_class_type class_ff [MSG_N]; // Class of each message
  logic [ST_N-1:0] stat_en_ff; // Enabled status signals
  rod_hold_type hold_ff; // Hold behaviour
  logic [31:0] ms_cnt_ff; // Millisecond divider
  logic ms_tick_ff; // One-cycle ms enable
  rod_pstate_type pstate_ff; // Pulse engine state
  logic [T1_W-1:0] on_cnt_ff; // Ms spent on
  logic [ACC_W-1:0] acc_ff; // Demand accumulated off
  logic coil_ff; // Relay coil drive
  logic map_rej_ff; // Mapping refused
  logic rate_rej_ff; // Rate refused
  logic map_rd_ff; // Read-back of map
  logic [MSG_N-1:0] class_hit; // Messages of selected class

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // alarm never modulates
  wire rod_func_type eff_func = (alarm_ff && FUNC_SEL == FN_CTRL) ? FN_DIAG : FUNC_SEL;
  wire rate_ok = RATE_VAL >= RATE_MIN && RATE_VAL <= RATE_MAX;
  wire map_ok = MSG_WR.map_we && eff_func == FN_DIAG;
  wire map_rej = MSG_WR.map_we && eff_func != FN_DIAG;
  always_comb begin
    for (int i = 0; i < MSG_N; i++) begin
      class_hit[i] = dmode_ff != DM_ASSIGNED && class_ff[i] == rod_class_type'(dmode_ff - DM_MAINT);
    end
  end
  wire assigned_fault = dmode_ff == DM_ASSIGNED && |(MSG_ACTIVE & map_ff);
  wire class_fault = |(MSG_ACTIVE & class_hit);
  wire diag_fault = assigned_fault || class_fault;
  // Ok signal faults when low, classes when high
  wire [ST_N-1:0] stat_bad = ASM_STATUS ^ (ST_N'(1) << ST_OK);
  wire stat_fault = |(stat_bad & stat_en_ff);
  wire fault = (eff_func == FN_DIAG && diag_fault) || (eff_func != FN_CTRL && stat_fault);
  wire [ACC_W-1:0] off_lim = ACC_W'(t1_ms_ff) * ACC_W'({1'b0, DEMAND_FULL, 1'b0} - {2'b00, DEMAND});
  // Sum including this ms, so full demand gives off equal to on
  wire [ACC_W-1:0] acc_sum = acc_ff + ACC_W'(DEMAND);
  wire pulse_out = pstate_ff == PS_ON;
  wire live_coil = eff_func == FN_CTRL ? pulse_out : !fault;
  wire nxt_coil = !HOLD || hold_ff == HB_IGNORE ? live_coil : hold_ff == HB_FIXED ? HOLD_FIXED : coil_ff;

  // ----------------------------------------
  // Configuration
  // ----------------------------------------
  // Settings and their reset values
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      alarm_ff <= ALARM_RELAY;
      dmode_ff <= ALARM_RELAY ? DM_FAIL : DM_ASSIGNED;
      rate_ff <= RATE_DEF;
      t1_ms_ff <= pulse_ms(RATE_DEF);
      stat_en_ff <= ST_RESET;
      hold_ff <= HB_IGNORE;
      map_rej_ff <= 1'b0;
      rate_rej_ff <= 1'b0;
    end else begin
      if (DMODE_WE) begin
        dmode_ff <= DMODE_VAL;
      end
      if (RATE_WE && rate_ok) begin
        rate_ff <= RATE_VAL;
        t1_ms_ff <= pulse_ms(RATE_VAL);
      end
      if (STAT_EN_WE) begin
        stat_en_ff <= STAT_EN_VAL;
      end
      if (HOLD_WE) begin
        hold_ff <= HOLD_VAL;
      end
      map_rej_ff <= map_rej;
      rate_rej_ff <= RATE_WE && !rate_ok;
    end
  end

  // Message map and classes
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      map_ff <= '0;
      for (int i = 0; i < MSG_N; i++) begin
        class_ff[i] <= CL_FAIL;
      end
    end else begin
      if (map_ok) begin
        map_ff[MSG_WR.idx] <= MSG_WR.map_val;
      end
      if (MSG_WR.class_we) begin
        class_ff[MSG_WR.idx] <= MSG_WR.class_val;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    map_rd_ff <= RST ? 1'b0 : map_ff[MAP_RD_IDX];
  end

  // ----------------------------------------
  // Pulse engine
  // ----------------------------------------
  // Millisecond enable
  always_ff @(posedge CLOCK) begin
    if (RST || ms_cnt_ff == 32'(MS_CYCLES - 1)) begin
      ms_cnt_ff <= '0;
      ms_tick_ff <= !RST;
    end else begin
      ms_cnt_ff <= ms_cnt_ff + 32'h1;
      ms_tick_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pstate_ff <= PS_OFF;
      on_cnt_ff <= '0;
      acc_ff <= '0;
    end else if (ms_tick_ff) begin
      case (pstate_ff)
        PS_OFF: begin
          if (DEMAND != 8'h00 && acc_sum >= off_lim) begin
            pstate_ff <= PS_ON;
            acc_ff <= '0;
          end else if (DEMAND != 8'h00) begin
            acc_ff <= acc_sum;
          end
        end
        PS_ON: begin
          if (on_cnt_ff + T1_W'(1) >= t1_ms_ff) begin
            pstate_ff <= PS_OFF;
            on_cnt_ff <= '0;
          end else begin
            on_cnt_ff <= on_cnt_ff + T1_W'(1);
          end
        end
        default: begin
          pstate_ff <= PS_OFF;
        end
      endcase
    end
  end

  // Coil drive
  always_ff @(posedge CLOCK) begin
    coil_ff <= RST ? 1'b0 : nxt_coil;
  end

  assign RELAY_COIL = coil_ff;
  assign MAP_REJECT = map_rej_ff;
  assign RATE_REJECT = rate_rej_ff;
  assign MAP_RD_DATA = map_rd_ff;
  assign RATE_NOW = rate_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  rate_range_a: assert property (rate_ff >= RATE_MIN && rate_ff <= RATE_MAX)
    else $error("rate out of range");
  pulse_len_a: assert property (RATE_WE && rate_ok |=> t1_ms_ff == pulse_ms($past(RATE_VAL)))
    else $error("pulse length not from rate");
  diag_failsafe_a: assert property (eff_func == FN_DIAG && !HOLD |=> coil_ff == !$past(fault))
    else $error("diagnostic coil not fail-safe");
  alarm_mode_a: assert property (alarm_ff && !HOLD && FUNC_SEL == FN_CTRL |=> coil_ff == !$past(fault))
    else $error("alarm relay modulated");
  assigned_only_a: assert property (dmode_ff == DM_ASSIGNED && (MSG_ACTIVE & map_ff) == '0 |-> !diag_fault)
    else $error("unmapped message drove relay");
  class_drive_a: assert property (dmode_ff == DM_FAIL && (MSG_ACTIVE & class_hit) != '0 |-> diag_fault)
    else $error("class message ignored");
  mode_default_a: assert property ($past(RST) |-> dmode_ff == (alarm_ff ? DM_FAIL : DM_ASSIGNED))
    else $error("wrong mode default");
  map_reject_a: assert property (map_rej |=> MAP_REJECT && map_ff == $past(map_ff))
    else $error("mapping not refused");
  stat_default_a: assert property ($past(RST) |-> stat_en_ff == ST_RESET && hold_ff == HB_IGNORE)
    else $error("status or hold default wrong");
  hold_freeze_a: assert property (HOLD && hold_ff == HB_FREEZE |=> $stable(coil_ff))
    else $error("freeze changed coil");
  on_len_a: assert property (pstate_ff == PS_ON |-> on_cnt_ff < t1_ms_ff)
    else $error("pulse too long");
  fault_or_a: assert property (eff_func == FN_DIAG && stat_fault |-> fault)
    else $error("status fault not combined");

  pulse_seen_c: cover property (eff_func == FN_CTRL && $rose(pstate_ff == PS_ON));
  diag_trip_c: cover property (eff_func == FN_DIAG && $fell(coil_ff));
  map_refused_c: cover property (map_rej);
  hold_fixed_c: cover property (HOLD && hold_ff == HB_FIXED);
endmodule : rod_relay

// File: rod_coil_model.sv
`timescale 1ns/1ps
// Relay coil with its actuator: times each energized and released stretch
module rod_coil_model (
  input wire logic CLOCK,
  input wire logic COIL,
  output logic [31:0] ON_LEN,
  output logic [31:0] OFF_LEN
);
  logic [31:0] run_ff = 32'h0; // Cycles in present state
  logic last_ff = 1'b0; // Coil state one edge ago
  // ------------------------------
  // Stretch timing
  // ------------------------------
  always_ff @(posedge CLOCK) begin
    last_ff <= COIL;
    if (COIL == last_ff) begin
      run_ff <= run_ff + 1;
    end else begin
      run_ff <= 1;
      if (last_ff) begin
        ON_LEN <= run_ff;
      end else begin
        OFF_LEN <= run_ff;
      end
    end
  end
endmodule : rod_coil_model

// File: rod_relay_tb.sv
`timescale 1ns/1ps
module rod_relay_tb;
  import rod_pkg::*;
  localparam int MSC = 4; // Short millisecond
  localparam int T1 = (30000 / 180) * MSC; // On time at rate 180
  typedef struct packed {rod_func_type f; rod_dmode_type m; logic [4:0] s; logic [15:0] a; logic [4:0] st; logic c;} rod_row_type;
  // ------------------------------
  // Signals
  // ------------------------------
  logic clock, rst, alarm_relay, dmode_we, rate_we, stat_en_we, hold, hold_we, hold_fixed;
  rod_func_type func_sel;
  rod_dmode_type dmode_val;
  rod_hold_type hold_val;
  logic [7:0] rate_val, demand, rate_now;
  rod_msg_wr_type msg_wr;
  logic [MSG_N-1:0] msg_active;
  logic [MSG_W-1:0] map_rd_idx;
  logic [ST_N-1:0] stat_en_val, asm_status;
  logic relay_coil, map_reject, rate_reject, map_rd_data;
  logic [31:0] on_len, off_len;
  int errors = 0, n_tests = 0, cyc = 0;
  // Function, mode, enables, messages, status, coil
  rod_row_type rows [12] = '{
    '{FN_DIAG, DM_ASSIGNED, 5'h00, 16'h0000, 5'h01, 1'b1}, '{FN_DIAG, DM_ASSIGNED, 5'h00, 16'h0004, 5'h01, 1'b0},
    '{FN_DIAG, DM_ASSIGNED, 5'h00, 16'h0008, 5'h01, 1'b1}, '{FN_DIAG, DM_FAIL, 5'h00, 16'h0008, 5'h01, 1'b0},
    '{FN_DIAG, DM_MAINT, 5'h00, 16'h0008, 5'h01, 1'b1}, '{FN_DIAG, DM_MAINT, 5'h00, 16'h0020, 5'h01, 1'b0},
    '{FN_DIAG, DM_SPEC, 5'h00, 16'h0008, 5'h01, 1'b1}, '{FN_DIAG, DM_CHECK, 5'h00, 16'h0020, 5'h01, 1'b1},
    '{FN_STAT, DM_ASSIGNED, 5'h01, 16'h0000, 5'h00, 1'b0}, '{FN_STAT, DM_ASSIGNED, 5'h18, 16'h0000, 5'h01, 1'b1},
    '{FN_STAT, DM_ASSIGNED, 5'h18, 16'h0000, 5'h11, 1'b0}, '{FN_DIAG, DM_ASSIGNED, 5'h10, 16'h0000, 5'h11, 1'b0}};
  // ------------------------------
  // Design and far side
  // ------------------------------
  rod_relay #(.MS_CYCLES(MSC)) dut (.CLOCK(clock), .RST(rst), .ALARM_RELAY(alarm_relay), .FUNC_SEL(func_sel),
    .DMODE_WE(dmode_we), .DMODE_VAL(dmode_val), .RATE_WE(rate_we), .RATE_VAL(rate_val), .DEMAND(demand),
    .MSG_WR(msg_wr), .MSG_ACTIVE(msg_active), .MAP_RD_IDX(map_rd_idx), .STAT_EN_WE(stat_en_we),
    .STAT_EN_VAL(stat_en_val), .ASM_STATUS(asm_status), .HOLD(hold), .HOLD_WE(hold_we), .HOLD_VAL(hold_val),
    .HOLD_FIXED(hold_fixed), .RELAY_COIL(relay_coil), .MAP_REJECT(map_reject), .RATE_REJECT(rate_reject),
    .MAP_RD_DATA(map_rd_data), .RATE_NOW(rate_now));
  rod_coil_model coil (.CLOCK(clock), .COIL(relay_coil), .ON_LEN(on_len), .OFF_LEN(off_len));
  // ------------------------------
  // Clock and hang guard
  // ------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 10000) begin
      errors++;
      complete_run();
    end
  end
  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  // Mode and status enables in one go
  task automatic cfg(rod_dmode_type m, logic [4:0] s);
    @(posedge clock);
    dmode_we <= 1'b1;
    dmode_val <= m;
    stat_en_we <= 1'b1;
    stat_en_val <= s;
    @(posedge clock);
    dmode_we <= 1'b0;
    stat_en_we <= 1'b0;
  endtask : cfg
  task automatic wr_rate(logic [7:0] v, logic rej, logic [7:0] now);
    @(posedge clock);
    rate_we <= 1'b1;
    rate_val <= v;
    @(posedge clock);
    rate_we <= 1'b0;
    #1;
    check("rate_reject", rate_reject, rej);
    check("rate_now", rate_now, now);
  endtask : wr_rate
  task automatic map_wr(logic [3:0] i, logic rej);
    @(posedge clock);
    msg_wr <= '{1'b1, 1'b0, i, 1'b1, CL_FAIL};
    @(posedge clock);
    msg_wr <= '0;
    #1;
    check("map_reject", map_reject, rej);
  endtask : map_wr
  task automatic map_rd(logic [3:0] i, logic exp);
    @(posedge clock);
    map_rd_idx <= i;
    tick(2);
    check("map_rd_data", map_rd_data, exp);
  endtask : map_rd
  task automatic hold_case(rod_hold_type v, logic [15:0] a, logic exp);
    @(posedge clock);
    hold_we <= 1'b1;
    hold_val <= v;
    hold <= 1'b1;
    @(posedge clock);
    hold_we <= 1'b0;
    msg_active <= a;
    tick(3);
    check("relay_coil_hold", relay_coil, exp);
  endtask : hold_case
  // Reset with given strap, function and messages
  task automatic do_reset(logic alarm, rod_func_type f, logic [15:0] a, logic exp);
    @(posedge clock);
    rst <= 1'b1;
    alarm_relay <= alarm;
    func_sel <= f;
    msg_active <= a;
    asm_status <= 5'h00;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    tick(3);
    check("relay_coil_reset", relay_coil, exp);
    check("rate_now_reset", rate_now, RATE_DEF);
  endtask : do_reset
  task automatic complete_run();
    if (errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    {alarm_relay, dmode_we, rate_we, stat_en_we, hold, hold_we, hold_fixed, rst} = 8'h01;
    func_sel = FN_DIAG;
    dmode_val = DM_ASSIGNED;
    hold_val = HB_IGNORE;
    {rate_val, demand} = 16'h0000;
    msg_wr = '0;
    {msg_active, map_rd_idx, stat_en_val, asm_status} = {16'h0000, 4'h0, 5'h00, 5'h01};
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    map_wr(4'h2, 1'b0);
    @(posedge clock) msg_wr <= '{1'b0, 1'b1, 4'h5, 1'b0, CL_MAINT};
    @(posedge clock) msg_wr <= '0;
    foreach (rows[i]) begin
      cfg(rows[i].m, rows[i].s);
      func_sel <= rows[i].f;
      msg_active <= rows[i].a;
      asm_status <= rows[i].st;
      tick(3);
      check("relay_coil", relay_coil, rows[i].c);
    end
    cfg(DM_ASSIGNED, 5'h00);
    func_sel <= FN_DIAG;
    msg_active <= 16'h0000;
    asm_status <= 5'h01;
    map_rd(4'h2, 1'b1);
    @(posedge clock) func_sel <= FN_CTRL;
    map_wr(4'h3, 1'b1);
    @(posedge clock) func_sel <= FN_STAT;
    map_wr(4'h4, 1'b1);
    map_rd(4'h3, 1'b0);
    @(posedge clock) func_sel <= FN_DIAG;
    hold_case(HB_FREEZE, 16'h0004, 1'b1);
    hold_case(HB_FIXED, 16'h0000, 1'b0);
    hold_case(HB_IGNORE, 16'h0000, 1'b1);
    wr_rate(8'h00, 1'b1, RATE_DEF);
    wr_rate(8'hb5, 1'b1, RATE_DEF);
    wr_rate(8'h01, 1'b0, 8'h01);
    wr_rate(8'hb4, 1'b0, 8'hb4);
    @(posedge clock);
    hold <= 1'b0;
    func_sel <= FN_CTRL;
    demand <= 8'hff;
    msg_active <= 16'h0000;
    tick(3000);
    check("on_len", on_len, T1);
    check("off_len", off_len, T1);
    do_reset(1'b0, FN_DIAG, 16'h000c, 1'b1);
    map_rd(4'h2, 1'b0);
    do_reset(1'b1, FN_CTRL, 16'h0000, 1'b1);
    do_reset(1'b1, FN_CTRL, 16'h0008, 1'b0);
    complete_run();
  end
endmodule : rod_relay_tb
